/* File: hw/sfr_defines.vh */
// Constants for the sanitize control and failed-block report block
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
// Register word offsets
`define SFR_REG_CTRL        4'h0
`define SFR_REG_STATUS      4'h1
`define SFR_REG_CMD         4'h2
`define SFR_REG_TFI         4'h3
`define SFR_REG_TFO         4'h4
`define SFR_REG_DATA        4'h5
`define SFR_REG_MEDIA       4'h6
`define SFR_REG_FAILCNT     4'h7
// Control fields
`define SFR_CTRL_RESUME     0
`define SFR_CTRL_FILL       1
`define SFR_CTRL_IRIG       2
`define SFR_CTRL_RESET      32'h0000_0001
// Command register trigger codes
`define SFR_CMD_SANITIZE    8'h21
`define SFR_CMD_SAN_BBM     8'h22
// Taskfile codes
`define SFR_OP_LIST         8'h81
`define SFR_OP_DATA         8'h83
`define SFR_FEAT_LIST       8'h07
`define SFR_CYL_LO_V        8'h56
`define SFR_CYL_HI_S        8'h53
`define SFR_CYL_HI_DIN      8'h80
`define SFR_SUB_LEN         8'h00
`define SFR_SUB_FIRST       8'h01
`define SFR_SUB_NEXT        8'h02
`define SFR_SUB_BLOCK       8'h03
`define SFR_SUB_BNEXT       8'h04
// Fill patterns
`define SFR_PAT_A           8'h55
`define SFR_PAT_B           8'hAA
// Sector layout
`define SFR_SECTOR_BYTES    10'h200
`define SFR_ENTRY_BYTES     10'h004
`define SFR_FAIL_DEPTH      8
// Timing in 10 ns clocks: 1000 ns blink half period, 2000 ns ready hold
`define SFR_BLINK_CYC       16'h0064
`define SFR_READY_CYC       16'h00C8
// Status bits, and the ABRT bit of the error byte
`define SFR_ST_ERR          8'h01
`define SFR_ST_DRQ          8'h08
`define SFR_ST_DRDY         8'h40
`define SFR_ST_ABRT         8'h04
`endif

/* File: hw/sfr_sync.v */
// Two-flop synchroniser for the sanitize interrupt level
`timescale 1ns/100ps
`default_nettype none
module sfr_sync (
   // Clock and reset
   input  wire i_clock,
   input  wire i_rstn,
   // Level in and out
   input  wire i_level,
   output reg  o_level
);
   reg meta_q;
   always @(posedge i_clock) begin
      if (!i_rstn) begin
         meta_q  <= 1'b0;
         o_level <= 1'b0;
      end else begin
         meta_q  <= i_level;
         o_level <= meta_q;
      end
   end
endmodule // sfr_sync
`default_nettype wire

/* File: hw/sfr_top.v */
// Sanitize sequencer and failed-block report over an Avalon-MM slave
//
// Overview of operation
// - Sanitize interrupt is sampled when idle or at end of ready hold and starts the default procedure
// - Default procedure erases whole media, no fill, unless reconfigured
// - Interrupt active at power-up starts the default procedure at once
// - Interrupt still active at completion restarts the procedure, indefinitely
// - With auto-resume on, a run cut by power loss restarts at power-up
// - Pending interrupted run finishes first, then interrupt relaunches default
// - Fill data mixes LFSR and true random input, seed differs each launch
// - Red LED lit in erase, blinks in fill, lit briefly before ready
// - Declassify: erase, write 55, erase, write AA, erase
// - After bad-block sanitize, cylinder high reads 80 for data-in
// - Report sector is 512 bytes: byte 0 failed count, rest zero
// - List command: features 07, 'V', 'S', mask, command 81, per sector
// - Never transfer more sectors than the host buffer size
// - Each failed block takes one four-byte entry in the list; only the first 8 are stored, later entries read zero
// - Data command 83: features subcode, count buffer; returns 80 and count
// - Subcode 00 returns the failed-data size in one sector
// - Subcode 01 sends data from the first block, aborts without prior 22
// - Subcode 02 sends next data, aborts at end or without prior 22
// - Subcode 03 sends requested block data, aborts without prior 22
// - Subcode 04 sends next data of one block, aborts at end or no 22
// - Sanitize code 22 runs sanitize with bad-block recording
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.vh"
module sfr_top (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_rstn,
   // Avalon-MM slave
   input  wire [3:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   output reg  [31:0] o_avs_readdata,
   output reg         o_avs_waitrequest,
   // Sanitize interrupt, retained power-loss flag, entropy
   input  wire        i_san_irq,
   input  wire        i_resume_pending,
   input  wire        i_trng_bit,
   // Media engine
   output reg         o_media_erase,
   output reg         o_media_fill,
   output reg  [7:0]  o_media_pattern,
   input  wire        i_media_done,
   input  wire        i_media_blk_fail,
   input  wire [31:0] i_media_blk_addr,
   output reg         o_run_active,
   // Indicator
   output reg         o_led_red
);
   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   localparam [6:0] S_IDLE = 7'h01, S_ER1 = 7'h02, S_WR1 = 7'h04,
                    S_ER2  = 7'h08, S_WR2 = 7'h10, S_ER3 = 7'h20,
                    S_RDY  = 7'h40;
   localparam [15:0] BLINK_CYC = `SFR_BLINK_CYC;
   localparam [15:0] READY_CYC = `SFR_READY_CYC;
   localparam [7:0]  N_SECT   = 8'h01;

   wire        irq_s;
   reg  [6:0]  st_q;
   reg         boot_q;
   reg         decl_q;     // Current run uses two-pass declassify
   reg         bbm_q;      // Current run records failed blocks
   reg         bbm_done_q; // A bad-block run has completed
   reg         dirty_q;    // Run in progress; feeds power-loss store
   reg  [31:0] ctrl_q;
   reg  [7:0]  fail_cnt_q;
   reg  [31:0] fail_mem [0:`SFR_FAIL_DEPTH-1];
   reg  [31:0] lfsr_q;
   reg  [31:0] launch_q;
   reg  [15:0] tmr_q;
   reg         kick_q;
   reg         kick_bbm_q;
   reg         kick_decl_q;

   sfr_sync u_sync (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_level (i_san_irq),
      .o_level (irq_s)
   );

   // ---------------------------------------------------------------
   // Random source
   // ---------------------------------------------------------------
   // Launch counter stirs the seed so identical starts still diverge
   always @(posedge i_clock) begin
      if (!i_rstn) begin
         lfsr_q <= 32'hACE1_2468;
      end else if (st_q == S_IDLE && kick_q) begin
         lfsr_q <= lfsr_q ^ launch_q ^ {31'h0, i_trng_bit};
      end else begin
         lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1]
                    ^ lfsr_q[0] ^ i_trng_bit};
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   wire start_req = kick_q | (boot_q & (i_resume_pending
                    & ctrl_q[`SFR_CTRL_RESUME])) | irq_s;
   wire fill_on   = ctrl_q[`SFR_CTRL_FILL];

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         st_q          <= S_IDLE;
         boot_q        <= 1'b1;
         decl_q        <= 1'b0;
         bbm_q         <= 1'b0;
         bbm_done_q    <= 1'b0;
         dirty_q       <= 1'b0;
         fail_cnt_q    <= 8'h00;
         launch_q      <= 32'h0000_0000;
         tmr_q         <= 16'h0000;
         o_media_erase <= 1'b0;
         o_media_fill  <= 1'b0;
         o_media_pattern <= 8'h00;
         o_run_active  <= 1'b0;
         o_led_red     <= 1'b0;
      end else begin
         boot_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               o_media_fill <= 1'b0;
               // Power-up resume, interrupt, software start all merge
               if (start_req) begin
                  st_q          <= S_ER1;
                  launch_q      <= launch_q + 32'h0000_0001;
                  decl_q        <= kick_q ? kick_decl_q : 1'b0;
                  bbm_q         <= kick_q & kick_bbm_q;
                  if (kick_q & kick_bbm_q) begin
                     fail_cnt_q <= 8'h00;
                  end
                  dirty_q       <= 1'b1;
                  o_media_erase <= 1'b1;
                  o_run_active  <= 1'b1;
                  o_led_red     <= 1'b1;
               end else begin
                  o_run_active  <= 1'b0;
               end
            end
            S_ER1, S_ER2, S_ER3: begin
               o_led_red <= 1'b1;
               if (i_media_done) begin
                  o_media_erase <= 1'b0;
                  if (st_q == S_ER3 || (!decl_q && !fill_on)) begin
                     st_q  <= S_RDY;
                     tmr_q <= READY_CYC;
                  end else if (st_q == S_ER1) begin
                     st_q            <= S_WR1;
                     o_media_fill    <= 1'b1;
                     o_media_pattern <= decl_q ? `SFR_PAT_A
                                               : lfsr_q[7:0];
                  end else if (!decl_q) begin
                     st_q  <= S_RDY;
                     tmr_q <= READY_CYC;
                  end else begin
                     st_q            <= S_WR2;
                     o_media_fill    <= 1'b1;
                     o_media_pattern <= `SFR_PAT_B;
                  end
               end
            end
            S_WR1, S_WR2: begin
               // Blink toggles on a free timer during fill
               if (tmr_q == 16'h0000) begin
                  tmr_q     <= BLINK_CYC;
                  o_led_red <= ~o_led_red;
               end else begin
                  tmr_q <= tmr_q - 16'h0001;
               end
               if (!decl_q) begin
                  o_media_pattern <= lfsr_q[7:0];
               end
               if (i_media_done) begin
                  o_media_fill  <= 1'b0;
                  o_media_erase <= 1'b1;
                  st_q          <= (st_q == S_WR1) ? S_ER2 : S_ER3;
               end
            end
            S_RDY: begin
               o_led_red <= 1'b1;
               if (tmr_q == 16'h0000) begin
                  o_led_red  <= 1'b0;
                  dirty_q    <= 1'b0;
                  bbm_done_q <= bbm_done_q | bbm_q;
                  if (irq_s) begin
                     st_q          <= S_ER1;
                     launch_q      <= launch_q + 32'h0000_0001;
                     decl_q        <= 1'b0;
                     bbm_q         <= 1'b0;
                     dirty_q       <= 1'b1;
                     o_media_erase <= 1'b1;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end else begin
                  tmr_q <= tmr_q - 16'h0001;
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
         if (bbm_q && i_media_blk_fail && o_media_erase &&
             fail_cnt_q != 8'hFF) begin
            fail_cnt_q <= fail_cnt_q + 8'h01;
         end
      end
   end

   always @(posedge i_clock) begin
      if (bbm_q && i_media_blk_fail && o_media_erase &&
          fail_cnt_q < `SFR_FAIL_DEPTH) begin
         fail_mem[fail_cnt_q[2:0]] <= i_media_blk_addr;
      end
   end

   // ---------------------------------------------------------------
   // Taskfile command interpreter
   // ---------------------------------------------------------------
   // Taskfile in: [31:24] cmd, [23:16] feat, [15:8] count, [7:0] cyl lo
   // Writing it runs the command; cylinder high and device are implied
   reg  [31:0] tfi_q;
   reg  [7:0]  tf_stat_q;
   reg  [7:0]  tf_err_q;
   reg  [7:0]  tf_cyl_lo_q;
   reg  [7:0]  tf_cyl_hi_q;
   reg  [9:0]  byte_q;      // Byte pointer inside current sector
   reg  [7:0]  sect_left_q; // Sectors still to hand out
   reg  [7:0]  rd_ptr_q;    // Next failed entry for pipeline reads
   reg  [7:0]  mode_q;
   reg  [31:0] dword;
   wire [7:0]  t_cmd  = i_avs_writedata[31:24];
   wire [7:0]  t_feat = i_avs_writedata[23:16];
   wire [7:0]  t_cnt  = i_avs_writedata[15:8];
   wire [7:0]  t_cyl  = i_avs_writedata[7:0];
   wire        wr     = i_avs_write & o_avs_waitrequest;
   wire        rd     = i_avs_read  & o_avs_waitrequest;
   wire [7:0]  ent    = rd_ptr_q + byte_q[9:2];

   always @* begin
      dword = 32'h0000_0000;
      case (mode_q)
         `SFR_SUB_LEN, `SFR_OP_DATA: begin
            if (byte_q == 10'h000) begin
               dword = {24'h0, fail_cnt_q};
            end
         end
         default: begin
            if (ent < fail_cnt_q && ent < `SFR_FAIL_DEPTH) begin
               dword = fail_mem[ent[2:0]];
            end
         end
      endcase
   end

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
         ctrl_q      <= `SFR_CTRL_RESET;
         tfi_q       <= 32'h0000_0000;
         tf_stat_q   <= `SFR_ST_DRDY;
         tf_err_q    <= 8'h00;
         tf_cyl_lo_q <= 8'h00;
         tf_cyl_hi_q <= 8'h00;
         byte_q      <= 10'h000;
         sect_left_q <= 8'h00;
         rd_ptr_q    <= 8'h00;
         mode_q      <= 8'h00;
         kick_q      <= 1'b0;
         kick_bbm_q  <= 1'b0;
         kick_decl_q <= 1'b0;
      end else begin
         o_avs_waitrequest <= 1'b1;
         if (st_q != S_IDLE) begin
            kick_q <= 1'b0;
         end
         if (st_q == S_RDY && tmr_q == 16'h0000 && bbm_q) begin
            tf_cyl_hi_q <= `SFR_CYL_HI_DIN;
            tf_cyl_lo_q <= N_SECT;
            tf_stat_q   <= `SFR_ST_DRDY | `SFR_ST_DRQ;
            mode_q      <= `SFR_OP_DATA;
            sect_left_q <= N_SECT;
            byte_q      <= 10'h000;
         end
         if ((wr | rd) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
         end
         if (wr && o_avs_waitrequest) begin
            case (i_avs_address)
               `SFR_REG_CTRL: ctrl_q <= i_avs_writedata;
               `SFR_REG_CMD: begin
                  if (st_q == S_IDLE &&
                      (i_avs_writedata[7:0] == `SFR_CMD_SANITIZE ||
                       i_avs_writedata[7:0] == `SFR_CMD_SAN_BBM)) begin
                     kick_q      <= 1'b1;
                     kick_bbm_q  <= i_avs_writedata[7:0]
                                    == `SFR_CMD_SAN_BBM;
                     kick_decl_q <= ctrl_q[`SFR_CTRL_IRIG];
                  end
               end
               `SFR_REG_TFI: begin
                  tfi_q       <= i_avs_writedata;
                  byte_q      <= 10'h000;
                  tf_err_q    <= 8'h00;
                  tf_stat_q   <= `SFR_ST_DRDY | `SFR_ST_DRQ;
                  tf_cyl_hi_q <= `SFR_CYL_HI_DIN;
                  if (t_cmd == `SFR_OP_LIST && t_feat == `SFR_FEAT_LIST &&
                      t_cyl == `SFR_CYL_LO_V && bbm_done_q) begin
                     mode_q      <= `SFR_SUB_FIRST;
                     rd_ptr_q    <= 8'h00;
                     // Entries per sector is 128; cap at host buffer
                     sect_left_q <= (t_cnt == 8'h00) ? 8'h00 : N_SECT;
                     tf_cyl_lo_q <= (t_cnt == 8'h00) ? 8'h00 : N_SECT;
                  end else if (t_cmd == `SFR_OP_DATA && t_cnt != 8'h00 &&
                     (t_feat == `SFR_SUB_LEN || (bbm_done_q &&
                      ((t_feat == `SFR_SUB_FIRST) ||
                       (t_feat == `SFR_SUB_BLOCK) ||
                       ((t_feat == `SFR_SUB_NEXT ||
                         t_feat == `SFR_SUB_BNEXT) &&
                        rd_ptr_q < fail_cnt_q))))) begin
                     mode_q      <= t_feat;
                     sect_left_q <= N_SECT;
                     tf_cyl_lo_q <= N_SECT;
                     if (t_feat == `SFR_SUB_FIRST) begin
                        rd_ptr_q <= 8'h00;
                     end else if (t_feat == `SFR_SUB_BLOCK) begin
                        rd_ptr_q <= t_cyl;
                     end
                  end else begin
                     // Abort: unknown code, no prior bad-block run, or end
                     tf_err_q    <= `SFR_ST_ABRT;
                     tf_stat_q   <= `SFR_ST_DRDY | `SFR_ST_ERR;
                     tf_cyl_lo_q <= 8'h00;
                     sect_left_q <= 8'h00;
                  end
               end
               default: begin
               end
            endcase
         end
         if (rd && o_avs_waitrequest) begin
            case (i_avs_address)
               `SFR_REG_CTRL:    o_avs_readdata <= ctrl_q;
               `SFR_REG_STATUS:  o_avs_readdata <= {16'h0, 5'h0, bbm_done_q,
                                  dirty_q, o_run_active, 1'b0, st_q};
               `SFR_REG_TFI:     o_avs_readdata <= tfi_q;
               `SFR_REG_TFO:     o_avs_readdata <= {tf_stat_q, tf_err_q,
                                  tf_cyl_hi_q, tf_cyl_lo_q};
               `SFR_REG_MEDIA:   o_avs_readdata <= {31'h0, dirty_q};
               `SFR_REG_FAILCNT: o_avs_readdata <= {24'h0, fail_cnt_q};
               `SFR_REG_DATA: begin
                  o_avs_readdata <= (sect_left_q != 8'h00) ? dword
                                    : 32'h0000_0000;
                  if (sect_left_q != 8'h00) begin
                     byte_q <= byte_q + `SFR_ENTRY_BYTES;
                     if (byte_q == `SFR_SECTOR_BYTES - `SFR_ENTRY_BYTES) begin
                        byte_q      <= 10'h000;
                        sect_left_q <= sect_left_q - 8'h01;
                        tf_stat_q   <= `SFR_ST_DRDY;
                        if (mode_q != `SFR_SUB_LEN &&
                            mode_q != `SFR_OP_DATA) begin
                           rd_ptr_q <= (fail_cnt_q > 8'h80) ?
                                       rd_ptr_q + 8'h80 : fail_cnt_q;
                        end
                     end
                  end
               end
               default:          o_avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // sfr_top
`default_nettype wire

/* File: test/sfr_top_props.sv */
// Port-level checks for the sanitize control block
`timescale 1ns/100ps
`default_nettype none
module sfr_top_props (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rstn,
   // Bus handshake
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   // Sanitize control
   input wire logic i_san_irq,
   input wire logic i_resume_pending,
   input wire logic o_media_erase,
   input wire logic o_media_fill,
   input wire logic o_run_active,
   input wire logic o_led_red
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);

   chk_bus_answer: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest) else $error("bus answer late");
   chk_bus_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("bus answer held too long");
   chk_irq_start: assert property (
      i_san_irq [*3] |-> ##[0:6] o_run_active) else $error("irq ignored");
   chk_irq_repeat: assert property (
      i_san_irq [*4] ##0 o_run_active |=> o_run_active)
      else $error("run dropped while irq held");
   chk_resume_start: assert property (
      $rose(i_rstn) && i_resume_pending |-> ##[0:6] o_run_active)
      else $error("cut run not resumed");
   chk_erase_led: assert property (
      o_media_erase [*2] |-> o_led_red) else $error("led dark in erase");
   chk_ready_led: assert property (
      $fell(o_media_erase) && !o_media_fill |-> o_led_red [*8])
      else $error("led not held");
   chk_phase_excl: assert property (
      !(o_media_erase && o_media_fill)) else $error("erase and fill together");
endmodule // sfr_top_props

bind sfr_top sfr_top_props u_props (.*);
`default_nettype wire

/* File: test/sfr_media_model.sv */
// Behavioural media engine answering erase and fill phases
`timescale 1ns/100ps
`default_nettype none
module sfr_media_model #(
   parameter int DLY = 20
) (
   // Clock and bench control
   input  wire logic        i_clock,
   input  wire logic        i_clr,
   input  wire logic [7:0]  i_fails,
   // Phase requests
   input  wire logic        i_erase,
   input  wire logic        i_fill,
   input  wire logic [7:0]  i_pattern,
   // Phase answers
   output var  logic        o_done,
   output var  logic        o_blk_fail,
   output var  logic [31:0] o_blk_addr,
   // Phase record for the bench
   output var  logic [7:0]  o_erases,
   output var  logic [7:0]  o_fills,
   output var  logic [7:0]  o_pat_first,
   output var  logic [7:0]  o_pat_last
);
   int         cnt_q = 0;
   logic [7:0] left_q = 8'h00;

   initial o_blk_addr = 32'h0;
   always @(posedge i_clock) begin
      o_done <= 1'b0;
      o_blk_fail <= 1'b0;
      // Address means nothing without the strobe, so keep it moving
      o_blk_addr <= ~o_blk_addr;
      if (i_clr) begin
         cnt_q <= 0;
         left_q <= i_fails;
         o_erases <= 8'h00;
         o_fills <= 8'h00;
      end else if ((i_erase || i_fill) && !o_done) begin
         cnt_q <= (cnt_q == DLY) ? 0 : cnt_q + 1;
         if (cnt_q == 1 && i_erase && left_q != 8'h00) begin
            o_blk_fail <= 1'b1;
            o_blk_addr <= {24'h0, left_q} + 32'h100;
            left_q <= left_q - 8'h01;
         end
         if (cnt_q == DLY) begin
            o_done <= 1'b1;
            o_erases <= o_erases + 8'(i_erase);
            o_fills <= o_fills + 8'(i_fill);
            if (i_fill && o_fills == 8'h00) o_pat_first <= i_pattern;
            if (i_fill) o_pat_last <= i_pattern;
         end
      end
   end
endmodule // sfr_media_model
`default_nettype wire

/* File: test/sfr_top_test.sv */
// Self-checking bench for the sanitize control block
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.vh"
module sfr_top_test;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        san_irq = 1'b0;
   logic        resume = 1'b0;
   logic        trng = 1'b0;
   logic        clr = 1'b1;
   logic [7:0]  fails = 8'h00;
   logic        waitreq, erase, fill, done, blk_fail, run, led;
   logic [7:0]  pattern, erases, fills, pat_first, pat_last;
   logic [31:0] avs_readdata, blk_addr, rd_q;
   logic [31:0] sec [128];
   int          error_cnt = 0;
   int          samples_checked = 0;

   always #5 clock = ~clock;
   always @(posedge clock) trng <= ~trng ^ run;

   sfr_top u_dut (.i_clock(clock), .i_rstn(rstn),
      .i_avs_address(avs_address), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(waitreq),
      .i_san_irq(san_irq), .i_resume_pending(resume), .i_trng_bit(trng),
      .o_media_erase(erase), .o_media_fill(fill), .o_media_pattern(pattern),
      .i_media_done(done), .i_media_blk_fail(blk_fail),
      .i_media_blk_addr(blk_addr), .o_run_active(run), .o_led_red(led));
   sfr_media_model u_media (.i_clock(clock), .i_clr(clr), .i_fails(fails),
      .i_erase(erase), .i_fill(fill), .i_pattern(pattern), .o_done(done),
      .o_blk_fail(blk_fail), .o_blk_addr(blk_addr), .o_erases(erases),
      .o_fills(fills), .o_pat_first(pat_first), .o_pat_last(pat_last));

   // ------------
   // Tasks
   // ------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
            output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (waitreq !== 1'b0 && n < 50) begin
         @(posedge clock);
         n++;
      end
      q = avs_readdata;
      chk("bus answer", 32'h0, 32'(waitreq));
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge keeps back-to-back calls from double driving
      @(posedge clock);
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd_q);
   endtask
   task rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, rd_q);
      chk(what, exp, rd_q);
   endtask
   task tfo_chk(input string what, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, `SFR_REG_TFO, 32'h0, rd_q);
      chk(what, e, rd_q & m);
   endtask
   task drain(input int k);
      int nz;
      nz = 0;
      for (int i = 0; i < 128; i++) begin
         bus(1'b0, `SFR_REG_DATA, 32'h0, rd_q);
         sec[i] = rd_q;
         if (i >= k && rd_q !== 32'h0) nz++;
      end
      chk("sector tail", 32'h0, 32'(nz));
   endtask
   task run_wait;
      int n;
      n = 0;
      while (run !== 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk("run start", 32'h1, 32'(run));
      n = 0;
      while (run !== 1'b0 && n < 8000) begin
         @(posedge clock);
         n++;
      end
      chk("run end", 32'h0, 32'(run));
      repeat (`SFR_READY_CYC + 4) @(posedge clock);
   endtask
   task new_run(input logic [7:0] f, input logic [31:0] ctrl);
      fails <= f;
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      wr(`SFR_REG_CTRL, ctrl);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      finish_test;
   end

   // ------------
   // Tests
   // ------------
   initial begin
      // Power-up with the interrupt high and a cut run pending
      san_irq <= 1'b1;
      resume <= 1'b1;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      clr <= 1'b0;
      repeat (10) @(posedge clock);
      resume <= 1'b0;
      chk("run after power-up", 32'h1, 32'(run));
      repeat (300) @(posedge clock);
      san_irq <= 1'b0;
      run_wait;
      chk("phases while held", 32'h1, 32'(erases >= 8'h02));
      chk("default fill", 32'h0, 32'(fills));
      $display("test power_up done");
      rdc("ctrl reset", `SFR_REG_CTRL, 32'h1);
      rdc("media clean", `SFR_REG_MEDIA, 32'h0);
      rdc("unmapped", 4'hF, 32'h0);
      for (int s = 1; s < 5; s++) begin
         wr(`SFR_REG_TFI, {8'h83, 8'(s), 16'h0100});
         tfo_chk("abort", 32'h01FF_0000, 32'h0104_0000);
      end
      $display("test aborts done");
      new_run(8'h00, 32'h3);
      wr(`SFR_REG_CMD, 32'h21);
      run_wait;
      wr(`SFR_REG_CMD, 32'h21);
      run_wait;
      chk("fill runs", 32'h2, 32'(fills));
      chk("seed differs", 32'h1, 32'(pat_first != pat_last));
      $display("test seed done");
      new_run(8'h02, 32'h5);
      wr(`SFR_REG_CMD, 32'h22);
      run_wait;
      chk("erase phases", 32'h3, 32'(erases));
      chk("first pattern", 32'h55, 32'(pat_first));
      chk("last pattern", 32'hAA, 32'(pat_last));
      rdc("fail count", `SFR_REG_FAILCNT, 32'h2);
      tfo_chk("report", 32'h0000_FFFF, 32'h0000_8001);
      drain(1);
      chk("count byte", 32'h2, sec[0]);
      $display("test declassify done");
      for (int s = 0; s < 4; s += 3) begin
         wr(`SFR_REG_TFI, {8'h83, 8'(s), 16'h0100});
         tfo_chk("data cmd", 32'h0000_FFFF, 32'h0000_8001);
         drain(s == 0 ? 1 : 2);
         // After 00: code 01 once, then 02 until exhausted; after 03: code 04 until exhausted
         for (int i = 0; i < 3; i++) begin
            wr(`SFR_REG_TFI,
               {8'h83, 8'((i == 0 || s > 0) ? s + 1 : 2), 16'h0100});
            bus(1'b0, `SFR_REG_TFO, 32'h0, rd_q);
            if (rd_q[23:16] !== 8'h04) drain(2);
         end
         chk("end of data", 32'h0004_0000, rd_q & 32'h00FF_0000);
      end
      wr(`SFR_REG_TFI, 32'h8107_0156);
      tfo_chk("list one", 32'h0000_00FF, 32'h1);
      drain(2);
      chk("entry 0", 32'h102, sec[0]);
      chk("entry 1", 32'h101, sec[1]);
      wr(`SFR_REG_TFI, 32'h8107_0056);
      tfo_chk("list none", 32'h0000_00FF, 32'h0);
      rdc("nothing pending", `SFR_REG_DATA, 32'h0);
      $display("test retrieval done");
      finish_test;
   end
endmodule // sfr_top_test
`default_nettype wire
